/* rtl/fsd_defs.svh */
// Timing counts, dither pattern and diagnostic pulse length for the flyback startup sequencer
// Assumes a 50 MHz clock; comparator inputs are already synchronous to it
// Contract
// - Drain above 20 V enables charge source; start threshold disables it and starts switching.
// - Below stop threshold or on fault, halt switching; idle-start or fault consumption.
// - After stop, recharge below recharge threshold until start threshold reached again.
// - First three cycles after each start limited to one third peak current.
// - While output charges after start, stay discontinuous and current-regulated until regulation.
// - Supply below 1 V gives reduced charge current; above it, higher current.
// - Sampled sense above 4.6 V declares output over-voltage fault.
// - Every fault uses same hiccup: discharge to recharge threshold, full restart.
// - During on-time compare sense-pin current to 75 uA shutdown and 210 uA enable; the code never reads vs_cur_above_210ua.
// - Input under-voltage fault only after three consecutive cycles.
// - Each cycle switch turns off when drain current reaches capped peak limit.
// - First over-current level on three consecutive cycles causes fault stop.
// - Second over-current level stops switching at once, no qualification.
// - Supply clamp current above about 6 mA is a fault.
// - Over-temperature stops switching and enters fault consumption.
// - Restart while still above about 100 C keeps switching off, fault held.
// - Thermal shutdown emits short diagnostic pulse on peak-current-set pin.
// - Regulation dither: 12 cycles, three groups of four: nominal, low f/high peak, high f/low peak.
// - Current-regulation mode dithers only the peak setting.
// - Dithering disabled in light-load wait state.
// - After fault hold fault consumption until stop threshold, then idle-start level.
`ifndef FSD_DEFS_SVH
`define FSD_DEFS_SVH
`define FSD_SOFT_CYCLES     2'd3
`define FSD_FAULT_CYCLES    2'd3
`define FSD_DITHER_LEN      4'd12
`define FSD_GROUP_LEN       3'd4
`define FSD_DIAG_PULSE_NS   2000
`define FSD_CLK_NS          20
`define FSD_DIAG_CYCLES     ((`FSD_DIAG_PULSE_NS + `FSD_CLK_NS - 1) / `FSD_CLK_NS)
`endif

/* rtl/fsd_pkg.sv */
// Types shared by the flyback startup sequencer
// Assumes the defs header is included by the design files
package fsd_pkg;
	typedef enum logic [4:0] {
		FSD_OFF    = 5'b0_0001,
		FSD_CHARGE = 5'b0_0010,
		FSD_RUN    = 5'b0_0100,
		FSD_FAULT  = 5'b0_1000,
		FSD_IDLE   = 5'b1_0000
	} fsd_state_t;
	typedef enum logic [1:0] {
		FSD_CONS_RUN   = 2'b00,
		FSD_CONS_START = 2'b01,
		FSD_CONS_FAULT = 2'b10
	} fsd_cons_t;
	typedef enum logic [1:0] {
		FSD_DITH_NOM  = 2'b00,
		FSD_DITH_SLOW = 2'b01,
		FSD_DITH_FAST = 2'b10
	} fsd_dith_t;
	// Comparator levels from the analog front end
	typedef struct packed {
		logic drain_above_20v;
		logic supply_above_1v;
		logic supply_above_start;
		logic supply_below_stop;
		logic supply_below_recharge;
	} fsd_supply_t;
	typedef struct packed {
		logic cycle_end;
		logic vs_over_4v6;
		logic vs_cur_below_75ua;
		logic vs_cur_above_210ua;
		logic drain_at_peak;
		logic drain_over_ocp1;
		logic drain_over_ocp2;
		logic clamp_over_6ma;
		logic over_temp;
		logic temp_above_100c;
		logic light_load_wait;
		logic output_in_reg;
	} fsd_sense_t;
	typedef struct packed {
		logic      charge_en;
		logic      charge_reduced;
		logic      switching_en;
		logic      soft_limit;
		logic      current_mode;
		fsd_cons_t consumption;
		fsd_dith_t freq_dither;
		fsd_dith_t peak_dither;
		logic      gate_off;
		logic      diag_pulse;
	} fsd_ctrl_t;
endpackage

/* rtl/fsd_qual.sv */
// Consecutive-cycle fault qualifier
// Assumes cyc marks one switching-cycle end per pulse
`timescale 1ns/10ps
module fsd_qual #(
	parameter int N = 3
) (
	input  wire logic clock,
	input  wire logic rstn,
	input  wire logic clr,
	input  wire logic cyc,
	input  wire logic cond,
	output logic      hit
);
	logic [3:0] cnt_q;
	initial begin
		if (N < 1 || N > 15) $error("fsd_qual: N out of range");
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 4'h0;
		end else if (clr) begin
			cnt_q <= 4'h0;
		end else if (cyc) begin
			if (!cond) cnt_q <= 4'h0;
			else if (cnt_q < 4'(N)) cnt_q <= cnt_q + 4'h1;
		end
	end
	assign hit = cyc && cond && (cnt_q == 4'(N - 1));
endmodule

/* rtl/fsd_seq.sv */
// Flyback startup, fault hiccup and dither sequencer
// Assumes comparator inputs synchronous to clock and one cycle_end pulse per switching cycle
`timescale 1ns/10ps
`include "fsd_defs.svh"
module fsd_seq #(
	parameter int QUAL_N = 3
) (
	input  wire logic                 clock,
	input  wire logic                 rstn,
	input  wire fsd_pkg::fsd_supply_t supply,
	input  wire fsd_pkg::fsd_sense_t  sense,
	output fsd_pkg::fsd_ctrl_t        ctrl_q
);
	import fsd_pkg::*;

	fsd_state_t state_q;
	fsd_state_t state_d;
	logic       thermal_q;
	logic [1:0] soft_q;
	logic [3:0] dith_q;
	logic [7:0] diag_q;
	logic       uv_hit;
	logic       ocp_hit;
	logic       fault_now;
	logic       therm_hold;
	logic       restart;
	logic       running;

	initial begin
		if (QUAL_N < 1 || QUAL_N > 15) $error("fsd_seq: QUAL_N out of range");
	end

	assign running = (state_q == FSD_RUN);
	assign restart = (state_q == FSD_CHARGE) && supply.supply_above_start;

	// Under-voltage is only meaningful with the sense pin clamped during on-time
	fsd_qual #(.N(QUAL_N)) u_uv (
		.clock (clock),
		.rstn  (rstn),
		.clr   (restart || !running),
		.cyc   (running && sense.cycle_end),
		.cond  (sense.vs_cur_below_75ua),
		.hit   (uv_hit)
	);

	fsd_qual #(.N(QUAL_N)) u_ocp (
		.clock (clock),
		.rstn  (rstn),
		.clr   (restart || !running),
		.cyc   (running && sense.cycle_end),
		.cond  (sense.drain_over_ocp1),
		.hit   (ocp_hit)
	);

	assign therm_hold = thermal_q && sense.temp_above_100c;
	assign fault_now  = running && (uv_hit || ocp_hit
		|| sense.drain_over_ocp2
		|| sense.clamp_over_6ma
		|| sense.over_temp
		|| (sense.cycle_end && sense.vs_over_4v6));

	always_comb begin
		state_d = state_q;
		case (state_q)
			FSD_OFF: begin
				if (supply.drain_above_20v) state_d = FSD_CHARGE;
			end
			FSD_CHARGE: begin
				if (supply.supply_above_start) begin
					if (therm_hold) state_d = FSD_FAULT;
					else state_d = FSD_RUN;
				end
			end
			FSD_RUN: begin
				if (fault_now) state_d = FSD_FAULT;
				else if (supply.supply_below_stop) state_d = FSD_IDLE;
			end
			FSD_FAULT: begin
				if (supply.supply_below_stop) state_d = FSD_IDLE;
			end
			FSD_IDLE: begin
				if (supply.supply_below_recharge) state_d = FSD_CHARGE;
			end
			default: state_d = FSD_OFF;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) state_q <= FSD_OFF;
		else state_q <= state_d;
	end

	// Thermal memory survives the hiccup so the restart can be refused
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			thermal_q <= 1'b0;
		end else if (running && sense.over_temp) begin
			thermal_q <= 1'b1;
		end else if (restart && !sense.temp_above_100c) begin
			thermal_q <= 1'b0;
		end
	end

	// Soft-start cycle count, rearmed on every start
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			soft_q <= 2'd0;
		end else if (state_d == FSD_RUN && state_q != FSD_RUN) begin
			soft_q <= 2'd0;
		end else if (running && sense.cycle_end && soft_q != `FSD_SOFT_CYCLES) begin
			soft_q <= soft_q + 2'd1;
		end
	end

	// Dither position advances once per switching cycle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dith_q <= 4'd0;
		end else if (!running || sense.light_load_wait) begin
			dith_q <= 4'd0;
		end else if (sense.cycle_end) begin
			if (dith_q == `FSD_DITHER_LEN - 4'd1) dith_q <= 4'd0;
			else dith_q <= dith_q + 4'd1;
		end
	end

	// Diagnostic pulse on the peak-set pin at thermal shutdown
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			diag_q <= 8'h00;
		end else if (running && sense.over_temp) begin
			diag_q <= 8'(`FSD_DIAG_CYCLES);
		end else if (diag_q != 8'h00) begin
			diag_q <= diag_q - 8'h01;
		end
	end

	function automatic fsd_dith_t group_of(input logic [3:0] pos);
		if (pos < 4'(`FSD_GROUP_LEN)) group_of = FSD_DITH_NOM;
		else if (pos < 4'(2 * `FSD_GROUP_LEN)) group_of = FSD_DITH_SLOW;
		else group_of = FSD_DITH_FAST;
	endfunction

	// Registered outputs, computed from next state so they change with it
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= '{charge_en: 1'b0, charge_reduced: 1'b1, switching_en: 1'b0, soft_limit: 1'b1,
				current_mode: 1'b1, consumption: FSD_CONS_START, freq_dither: FSD_DITH_NOM,
				peak_dither: FSD_DITH_NOM, gate_off: 1'b1, diag_pulse: 1'b0};
		end else begin
			ctrl_q.charge_en      <= (state_d == FSD_CHARGE);
			ctrl_q.charge_reduced <= !supply.supply_above_1v;
			ctrl_q.switching_en   <= (state_d == FSD_RUN);
			// soft_q still holds the last run's count on the entry edge, so entry itself forces the limit
			ctrl_q.soft_limit     <= (soft_q != `FSD_SOFT_CYCLES) || state_d != FSD_RUN || !running;
			ctrl_q.current_mode   <= !sense.output_in_reg || state_d != FSD_RUN;
			ctrl_q.consumption    <= (state_d == FSD_FAULT) ? FSD_CONS_FAULT :
				(state_d == FSD_RUN) ? FSD_CONS_RUN : FSD_CONS_START;
			// Current loop owns frequency in current mode, so only peak is dithered
			ctrl_q.freq_dither    <= (state_d == FSD_RUN && sense.output_in_reg && !sense.light_load_wait)
				? group_of(dith_q) : FSD_DITH_NOM;
			ctrl_q.peak_dither    <= (state_d == FSD_RUN && !sense.light_load_wait)
				? group_of(dith_q) : FSD_DITH_NOM;
			ctrl_q.gate_off       <= state_d != FSD_RUN || sense.drain_at_peak;
			ctrl_q.diag_pulse     <= (running && sense.over_temp) || (diag_q > 8'h01);
		end
	end

	property p_ocp2;
		@(posedge clock) disable iff (!rstn)
		(running && sense.drain_over_ocp2) |=> (state_q == FSD_FAULT) ##1 !ctrl_q.switching_en;
	endproperty
	ocp2_stop_a: assert property (p_ocp2) else $error("ocp2 did not stop");

	fault_cons_a: assert property (@(posedge clock) disable iff (!rstn)
		(state_q == FSD_FAULT) |-> ctrl_q.consumption == FSD_CONS_FAULT) else $error("fault consumption");

	idle_recharge_a: assert property (@(posedge clock) disable iff (!rstn)
		(state_q == FSD_IDLE && supply.supply_below_recharge) |=> ctrl_q.charge_en) else $error("no recharge");

	start_run_a: assert property (@(posedge clock) disable iff (!rstn)
		(restart && !therm_hold) |=> running && ctrl_q.switching_en && !ctrl_q.charge_en) else $error("no start");

	therm_hold_a: assert property (@(posedge clock) disable iff (!rstn)
		(restart && therm_hold) |=> state_q == FSD_FAULT) else $error("thermal restart allowed");

	soft_start_a: assert property (@(posedge clock) disable iff (!rstn)
		$rose(running) |-> soft_q == 2'd0 ##1 ctrl_q.soft_limit) else $error("soft start missing");

	uv_qual_a: assert property (@(posedge clock) disable iff (!rstn)
		uv_hit |-> sense.cycle_end && sense.vs_cur_below_75ua && u_uv.cnt_q == 4'(QUAL_N - 1))
		else $error("uv qualified early");

	dither_wrap_a: assert property (@(posedge clock) disable iff (!rstn)
		(running && sense.cycle_end && dith_q == 4'd11 && !sense.light_load_wait) |=> dith_q == 4'd0)
		else $error("dither wrap");

	wait_nodither_a: assert property (@(posedge clock) disable iff (!rstn)
		sense.light_load_wait |=> ctrl_q.peak_dither == FSD_DITH_NOM) else $error("dither in wait");

	diag_len_a: assert property (@(posedge clock) disable iff (!rstn)
		(running && sense.over_temp) |=> ctrl_q.diag_pulse [*8]) else $error("diag pulse short");
endmodule

/* tb/fsd_seq_tb.sv */
// Bench for the flyback sequencer: startup, soft cycles, dither, faults, hiccup
// Assumes the stage model closes the supply loop around the sequencer
`timescale 1ns/10ps
`include "fsd_defs.svh"
module fsd_seq_tb;
	import fsd_pkg::*;
	logic        clock    = 0;
	logic        rstn     = 0;
	logic        drain_on = 0;
	logic        aux_ok   = 1;
	logic        p;
	logic        r;
	logic [3:0]  per      = 4'h8;
	logic [1:0]  q[$];
	fsd_sense_t  env      = '0;
	fsd_supply_t supply;
	fsd_sense_t  sense;
	fsd_ctrl_t   ctrl_q;
	int          errors   = 0;
	int          n_tests  = 0;
	int          seed     = 69864;
	int          n;
	int          e;
	int          d;
	int          fk[6]    = '{10, 9, 6, 5, 4, 3};
	int          fn[6]    = '{1, 3, 3, 0, 0, 0};
	always #10 clock = ~clock;
	fsd_seq uut (.clock(clock), .rstn(rstn), .supply(supply), .sense(sense), .ctrl_q(ctrl_q));
	fsd_stage stage (.clock(clock), .drain_on(drain_on), .aux_ok(aux_ok), .per(per), .env(env),
		.ctrl_q(ctrl_q), .supply(supply), .sense(sense));
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
		n_tests++;
		if (s !== x) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wt(input int b, input logic v);
		for (int k = 0; k < 3000 && ctrl_q[b] !== v; k++) begin
			p = supply.supply_below_recharge;
			@(negedge clock);
		end
	endtask
	task automatic sync();
		do @(negedge clock); while (sense.cycle_end !== 1'b1);
		@(posedge clock);
		#1;
	endtask
	// Count cycle ends while switching (s=0) or soft limit (s=1) holds
	task automatic cnt(input bit s);
		n = 0;
		for (e = 0; e < 3000; e++) begin
			@(negedge clock);
			if (ctrl_q[s ? 9 : 10] !== 1'b1)
				break;
			n += sense.cycle_end;
		end
	endtask
	// Dither samples at cycle ends; md 0 regulation, 1 current mode, 2 light load
	task automatic samp(input int m, input int md);
		int j;
		q = {};
		while (q.size() < m) begin
			@(negedge clock);
			if (sense.cycle_end === 1'b1) begin
				q.push_back(ctrl_q.peak_dither);
				chk("fdith", ctrl_q.freq_dither, md == 0 ? ctrl_q.peak_dither : FSD_DITH_NOM);
			end
		end
		for (j = 1; j < 5 && q[j] == q[0]; j++);
		for (int i = j; i < m; i++)
			chk("pdith", q[i], md == 2 ? 0 : 16'((q[j] + (i - j) / 4) % 3));
		if (md != 2)
			chk("pstep", q[j], 16'((q[j - 1] + 1) % 3));
	endtask
	initial begin
		#1_000_000;
		errors++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge clock);
		#1 rstn = 1;
		repeat (5) @(negedge clock);
		chk("rst", 16'(ctrl_q), 16'h0b42);
		chk("chg_idle", ctrl_q.charge_en, 0);
		@(posedge clock) #1 drain_on = 1;
		repeat (2) @(negedge clock);
		chk("chg_on", ctrl_q.charge_en, 1);
		r = 0;
		for (int k = 0; k < 500 && ctrl_q.switching_en !== 1'b1; k++) begin
			if (ctrl_q.charge_en === 1'b1)
				chk("reduced", ctrl_q.charge_reduced, !r);
			r = supply.supply_above_1v;
			@(negedge clock);
		end
		chk("start", {ctrl_q.charge_en, ctrl_q.soft_limit, ctrl_q.current_mode}, 3'b011);
		cnt(1);
		chk("soft", n, 3);
		$display("startup done");
		@(posedge clock) #1 env.output_in_reg = 1;
		samp(24, 0);
		@(posedge clock) #1 env.output_in_reg = 0;
		samp(12, 1);
		chk("ccmode", ctrl_q.current_mode, 1);
		@(posedge clock) #1 env.light_load_wait = 1;
		samp(8, 2);
		@(posedge clock) #1 env.light_load_wait = 0;
		$display("dither done");
		foreach (fk[f]) begin
			wt(10, 1);
			per = 4'(6 + ($random(seed) & 7));
			sync();
			// One clean cycle inside the run must restart the qualification
			if (fk[f] == 9) begin
				env[9] = 1;
				sync();
				sync();
				env[9] = 0;
				sync();
			end
			env[fk[f]] = 1;
			if (fk[f] == 3)
				env.temp_above_100c = 1;
			cnt(0);
			chk("pulses", n, fn[f]);
			if (fn[f] == 0)
				chk("edges", e, 1);
			chk("cons", ctrl_q.consumption, FSD_CONS_FAULT);
			@(posedge clock) #1 env[fk[f]] = 0;
			if (fk[f] == 3) begin
				for (d = 0; d < 400 && ctrl_q.diag_pulse === 1'b1; d++)
					@(negedge clock);
				chk("diag", d, `FSD_DIAG_CYCLES);
				wt(12, 1);
				wt(12, 0);
				repeat (20) @(negedge clock);
				chk("hot", {ctrl_q.switching_en, ctrl_q.consumption}, {1'b0, FSD_CONS_FAULT});
				@(posedge clock) #1 env.temp_above_100c = 0;
			end
			wt(12, 1);
			chk("recharge", p, 1);
			chk("cons_idle", ctrl_q.consumption, FSD_CONS_START);
			wt(10, 1);
			chk("restart", ctrl_q.soft_limit, 1);
			$display("fault %0d done", fk[f]);
		end
		@(posedge clock) #1 aux_ok = 0;
		wt(10, 0);
		chk("stop", {ctrl_q.consumption, supply.supply_below_stop}, {FSD_CONS_START, 1'b1});
		@(posedge clock) #1 aux_ok = 1;
		wt(10, 1);
		chk("rerun", ctrl_q.switching_en, 1);
		$display("stop threshold done");
		close_out();
	end
endmodule

/* tb/fsd_stage.sv */
// Power stage model: supply capacitor, aux winding, switching-cycle timing
// Assumes ctrl_q from the sequencer; fault levels and cycle period from the bench
`timescale 1ns/10ps
module fsd_stage (
	input  wire logic                clock,
	input  wire logic                drain_on,
	input  wire logic                aux_ok,
	input  wire logic [3:0]          per,
	input  wire fsd_pkg::fsd_sense_t env,
	input  wire fsd_pkg::fsd_ctrl_t  ctrl_q,
	output fsd_pkg::fsd_supply_t     supply,
	output fsd_pkg::fsd_sense_t      sense
);
	import fsd_pkg::*;
	int vdd = 0;
	int ph  = 0;
	// Supply in tenths of a volt; aux winding holds it while switching
	always @(posedge clock) begin
		#1;
		if (ctrl_q.charge_en && drain_on)
			vdd = vdd + (ctrl_q.charge_reduced ? 1 : 4);
		else if (ctrl_q.switching_en && aux_ok)
			vdd = 90;
		else if (vdd > 0)
			vdd = vdd - 1;
		ph = ctrl_q.switching_en ? (ph + 1) % per : 0;
	end
	// Combinational so bench level changes never race the model's clocked update
	assign supply = {drain_on, vdd >= 10, vdd >= 100, vdd < 60, vdd < 40};
	assign sense  = {ctrl_q.switching_en && ph == per - 1, env[10:8],
		ctrl_q.switching_en && ph == per - 3, env[6:0]};
endmodule
